// *** gtc_pkg.sv ***
// Package of constants and types for the gated 16-bit timer/counter
`default_nettype none
package gtc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COUNT_LOW_BYTE = 8'h04;
    localparam logic [7:0] OFF_COUNT_HIGH_BYTE = 8'h08;
    localparam logic [7:0] OFF_COMPARATOR_AUX_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // timer_control field positions
    localparam int CTL_TIMER_RUN = 0;
    localparam int CTL_CLOCK_SOURCE_SEL = 1;
    localparam int CTL_EXT_SYNC_BYPASS = 2;
    localparam int CTL_LP_OSC_EN = 3;
    localparam int CTL_PRESCALE_LO = 4;
    localparam int CTL_PRESCALE_HI = 5;
    localparam int CTL_GATE_QUALIFY_EN = 6;
    localparam int CTL_GATE_POLARITY = 7;
    // comparator_aux_control field position
    localparam int AUX_GATE_SOURCE_SEL = 1;
    // Status and mask field position
    localparam int IRQ_OVERFLOW = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h02;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    // Instruction clock is the core clock divided by four
    localparam int FOSC_DIVIDE = 4;
    localparam logic [1:0] DIV_LAST = 2'(FOSC_DIVIDE - 1);
    localparam logic [2:0] PRE_ONE = 3'h1;
    // Indices into the pin synchroniser vector
    localparam int SI_COUNT = 0;
    localparam int SI_GATE = 1;
    localparam int SI_CMP = 2;
    localparam int SI_LPOSC = 3;
    localparam int SYNC_W = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        GTC_BUS_IDLE = 2'h0,
        GTC_BUS_WAIT = 2'h1,
        GTC_BUS_DONE = 2'h3
    } gtc_bus_e;

    typedef struct packed {
        gtc_bus_e bus;
        logic [7:0] addr;
        logic wr;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] aux;
        logic [15:0] count;
        logic [2:0] pre;
        logic [1:0] div;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        logic pend;
        logic armed;
        logic flag;
        logic mask;
    } gtc_state_s;
endpackage : gtc_pkg
`default_nettype wire

// *** gtc_timer.sv ***
// Gated 16-bit timer/counter with AHB-Lite register slave
// Behaviour
// - gate polarity bit picks counting gate level
// - polarity applies equally to both gate sources
// - gate qualifies counting only while running
// - aux register selects gate pin or comparator
// - prescaler divides by 1, 2, 4, 8
// - oscillator enable bit turns LP oscillator
// - external input synchronised unless bypass bit set
// - internal source ignores the bypass bit
// - source bit selects external input (pin, or LP oscillator when enabled) or Fosc/4
// - run bit starts counting, clear holds count
// - count readable as low and high bytes
// - count wraps to zero and sets flag
// - count byte write clears the prescaler
// - external mode counts on rising input edges
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module gtc_timer (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic ext_count_input,
    input wire logic gate_pin,
    input wire logic second_comparator_output,
    input wire logic lp_osc_clk,
    output logic lp_osc_en,
    output logic irq
);
    import gtc_pkg::*;

    gtc_state_s st_q;
    gtc_state_s st_d;
    logic [SYNC_W-1:0] agree;
    logic instr_en;
    logic cnt_old;
    logic cnt_new;
    logic rise;
    logic fall;
    logic ext_tick;
    logic src_tick;
    logic gate_lvl;
    logic gate_act;
    logic count_en;
    logic [2:0] pre_last;
    logic inc;
    logic ovf;
    logic acc;
    logic wr_cyc;
    logic cnt_wr;

    always_comb begin
        st_d = st_q;
        // Three-stage synchronisers; a level is accepted once stages two and three agree
        st_d.s1 = {lp_osc_clk, second_comparator_output, gate_pin, ext_count_input};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        agree = ~(st_q.s2 ^ st_q.s3);
        st_d.filt = (agree & st_q.s3) | (~agree & st_q.filt);
        st_d.div = st_q.div + 2'h1;
        instr_en = (st_q.div == DIV_LAST);
        // LP oscillator replaces the count pin while it is enabled
        if (st_q.ctrl[CTL_LP_OSC_EN]) begin
            cnt_old = st_q.filt[SI_LPOSC];
            cnt_new = st_d.filt[SI_LPOSC];
        end else begin
            cnt_old = st_q.filt[SI_COUNT];
            cnt_new = st_d.filt[SI_COUNT];
        end
        rise = cnt_new & ~cnt_old;
        fall = ~cnt_new & cnt_old;
        // A falling edge must be seen before the first counted rising edge
        if (fall) begin
            st_d.armed = 1'b1;
        end
        if (st_q.ctrl[CTL_EXT_SYNC_BYPASS]) begin
            ext_tick = rise & st_q.armed;
            st_d.pend = 1'b0;
        end else begin
            ext_tick = instr_en & st_q.pend;
            st_d.pend = (st_q.pend & ~instr_en) | (rise & st_q.armed);
        end
        src_tick = st_q.ctrl[CTL_CLOCK_SOURCE_SEL] ? ext_tick : instr_en;
        gate_lvl = st_q.aux[AUX_GATE_SOURCE_SEL] ? st_q.filt[SI_GATE] : st_q.filt[SI_CMP];
        gate_act = st_q.ctrl[CTL_GATE_POLARITY] ? gate_lvl : ~gate_lvl;
        count_en = st_q.ctrl[CTL_TIMER_RUN]
            & (~st_q.ctrl[CTL_GATE_QUALIFY_EN] | gate_act);
        pre_last = 3'((4'(PRE_ONE) << st_q.ctrl[CTL_PRESCALE_HI:CTL_PRESCALE_LO]) - 4'h1);
        inc = src_tick & count_en & (st_q.pre == pre_last);
        if (src_tick && count_en) begin
            st_d.pre = inc ? 3'h0 : st_q.pre + PRE_ONE;
        end
        ovf = inc & (st_q.count == COUNT_MAX);
        st_d.count = st_q.count + {15'h0000, inc};
        st_d.flag = st_q.flag | ovf;
        // Bus slave: one wait cycle in every data phase
        acc = hsel & (htrans == HTRANS_NONSEQ) & hready;
        wr_cyc = (st_q.bus == GTC_BUS_WAIT) & st_q.wr;
        cnt_wr = wr_cyc & ((st_q.addr == OFF_COUNT_LOW_BYTE)
            | (st_q.addr == OFF_COUNT_HIGH_BYTE));
        unique case (st_q.bus)
            GTC_BUS_IDLE, GTC_BUS_DONE: begin
                if (acc) begin
                    st_d.bus = GTC_BUS_WAIT;
                    st_d.addr = haddr[7:0];
                    st_d.wr = hwrite;
                end else begin
                    st_d.bus = GTC_BUS_IDLE;
                end
            end
            GTC_BUS_WAIT: begin
                st_d.bus = GTC_BUS_DONE;
                st_d.rdata = RDATA_ZERO;
                unique case (st_q.addr)
                    OFF_TIMER_CONTROL: st_d.rdata[7:0] = st_q.ctrl;
                    OFF_COUNT_LOW_BYTE: st_d.rdata[7:0] = st_q.count[7:0];
                    OFF_COUNT_HIGH_BYTE: st_d.rdata[7:0] = st_q.count[15:8];
                    OFF_COMPARATOR_AUX_CONTROL: st_d.rdata[7:0] = st_q.aux;
                    OFF_IRQ_STATUS: st_d.rdata[IRQ_OVERFLOW] = st_q.flag;
                    OFF_IRQ_MASK: st_d.rdata[IRQ_OVERFLOW] = st_q.mask;
                    default: st_d.rdata = RDATA_ZERO;
                endcase
            end
            default: st_d.bus = GTC_BUS_IDLE;
        endcase
        if (wr_cyc) begin
            unique case (st_q.addr)
                OFF_TIMER_CONTROL: st_d.ctrl = hwdata[7:0];
                OFF_COUNT_LOW_BYTE: st_d.count[7:0] = hwdata[7:0];
                OFF_COUNT_HIGH_BYTE: st_d.count[15:8] = hwdata[7:0];
                OFF_COMPARATOR_AUX_CONTROL: st_d.aux = hwdata[7:0];
                // Overflow in the same cycle as the clear wins
                OFF_IRQ_STATUS: st_d.flag = ovf | (st_q.flag & ~hwdata[IRQ_OVERFLOW]);
                OFF_IRQ_MASK: st_d.mask = hwdata[IRQ_OVERFLOW];
                default: st_d.mask = st_q.mask;
            endcase
        end
        // A count write beats an increment in the written byte and restarts the prescaler and edge arming
        if (cnt_wr) begin
            st_d.pre = 3'h0;
            st_d.pend = 1'b0;
            st_d.armed = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q.bus <= GTC_BUS_IDLE;
            st_q.addr <= OFF_TIMER_CONTROL;
            st_q.wr <= 1'b0;
            st_q.rdata <= RDATA_ZERO;
            st_q.ctrl <= CTRL_RST;
            st_q.aux <= AUX_RST;
            st_q.count <= COUNT_RST;
            st_q.pre <= 3'h0;
            st_q.div <= 2'h0;
            st_q.s1 <= '0;
            st_q.s2 <= '0;
            st_q.s3 <= '0;
            st_q.filt <= '0;
            st_q.pend <= 1'b0;
            st_q.armed <= 1'b0;
            st_q.flag <= 1'b0;
            st_q.mask <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout = (st_q.bus != GTC_BUS_WAIT);
    assign hrdata = st_q.rdata;
    assign hresp = HRESP_OKAY;
    assign lp_osc_en = st_q.ctrl[CTL_LP_OSC_EN];
    assign irq = st_q.flag & st_q.mask;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_gate_polarity;
        st_q.ctrl[CTL_TIMER_RUN] && st_q.ctrl[CTL_GATE_QUALIFY_EN] && !gate_act && !cnt_wr
            |=> st_q.count == $past(st_q.count);
    endproperty
    a_gate_polarity: assert property (p_gate_polarity) else $error("count moved, gate closed");

    // Selected source at the inactive level must freeze the count, whichever source it is
    property p_gate_source;
        st_q.ctrl[CTL_TIMER_RUN] && st_q.ctrl[CTL_GATE_QUALIFY_EN] && !cnt_wr
            && ((st_q.aux[AUX_GATE_SOURCE_SEL] ? st_q.filt[SI_GATE] : st_q.filt[SI_CMP])
            != st_q.ctrl[CTL_GATE_POLARITY]) |=> st_q.count == $past(st_q.count);
    endproperty
    a_gate_source: assert property (p_gate_source) else $error("gate source or polarity wrong");

    property p_free_run;
        st_q.ctrl[CTL_TIMER_RUN] && !st_q.ctrl[CTL_GATE_QUALIFY_EN] && src_tick
            && st_q.pre == pre_last && !cnt_wr |=> st_q.count == $past(st_q.count) + 16'h1;
    endproperty
    a_free_run: assert property (p_free_run) else $error("ungated timer missed a count");

    property p_prescale;
        inc |-> st_q.pre == 3'((4'h1 << st_q.ctrl[CTL_PRESCALE_HI:CTL_PRESCALE_LO]) - 4'h1);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler terminal count wrong");

    property p_osc_enable;
        wr_cyc && st_q.addr == OFF_TIMER_CONTROL |=> lp_osc_en == $past(hwdata[CTL_LP_OSC_EN]);
    endproperty
    a_osc_enable: assert property (p_osc_enable) else $error("oscillator enable not followed");

    property p_internal_rate;
        !st_q.ctrl[CTL_CLOCK_SOURCE_SEL] && st_q.div != DIV_LAST && !cnt_wr
            |=> st_q.count == $past(st_q.count);
    endproperty
    a_internal_rate: assert property (p_internal_rate) else $error("internal count off Fosc/4");

    property p_stop_hold;
        !st_q.ctrl[CTL_TIMER_RUN] && !cnt_wr |=> st_q.count == $past(st_q.count);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped timer changed count");

    property p_reset_ctrl;
        $past(!rstn) |-> st_q.ctrl == CTRL_RST && !irq;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared by reset");

    property p_wrap;
        inc && st_q.count == COUNT_MAX && !cnt_wr |=> st_q.count == COUNT_RST && st_q.flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag");

    property p_pre_clear;
        cnt_wr |=> st_q.pre == 3'h0 ##1 st_q.pre <= PRE_ONE;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("count write kept prescale");

    property p_ext_bypass;
        st_q.ctrl[CTL_CLOCK_SOURCE_SEL] && st_q.ctrl[CTL_EXT_SYNC_BYPASS] && count_en
            && rise && st_q.armed && st_q.pre == pre_last && !cnt_wr
            |=> st_q.count == $past(st_q.count) + 16'h1;
    endproperty
    a_ext_bypass: assert property (p_ext_bypass) else $error("unsynced edge not counted");

    property p_ext_sync;
        st_q.ctrl[CTL_CLOCK_SOURCE_SEL] && !st_q.ctrl[CTL_EXT_SYNC_BYPASS] && rise
            && st_q.armed && !cnt_wr |-> ##[1:5] (st_q.pend == 1'b0);
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("synced edge never consumed");

    c_overflow: cover property (ovf && st_q.mask);
    c_gated_count: cover property (inc && st_q.ctrl[CTL_GATE_QUALIFY_EN]);
    c_ext_count: cover property (inc && st_q.ctrl[CTL_CLOCK_SOURCE_SEL]);
    c_prescale8: cover property (inc && st_q.ctrl[CTL_PRESCALE_HI:CTL_PRESCALE_LO] == 2'h3);
endmodule : gtc_timer
`default_nettype wire

// *** gtc_far_end.sv ***
// Model of the pins around the timer: count input, gate sources, LP oscillator
`default_nettype none
module gtc_far_end (
    input wire logic core_clk,
    input wire logic lp_osc_en,
    output logic ext_count_input,
    output logic gate_pin,
    output logic second_comparator_output,
    output logic lp_osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lp_div_q = 4'h0;
    initial begin
        ext_count_input = 1'b1;
        gate_pin = 1'b0;
        second_comparator_output = 1'b0;
        lp_osc_clk = 1'b0;
    end
    // Oscillator stays low while it is switched off
    always @(posedge core_clk) begin
        lp_div_q <= lp_div_q + 4'h1;
        lp_osc_clk <= lp_osc_en & lp_div_q[3];
    end
    // One pulse: falling edge first, so each rise counts; 8 core cycles
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge core_clk);
            ext_count_input <= 1'b0;
            repeat (4) @(posedge core_clk);
            ext_count_input <= 1'b1;
            repeat (3) @(posedge core_clk);
        end
    endtask : pulses
    task automatic set_gate(input logic pin, input logic cmp);
        @(posedge core_clk);
        gate_pin <= pin;
        second_comparator_output <= cmp;
    endtask : set_gate
endmodule : gtc_far_end
`default_nettype wire

// *** gtc_timer_test.sv ***
// Self-checking bench for the gated timer over AHB-Lite
`default_nettype none
module gtc_timer_test;
    import gtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, lp_osc_en, irq, lp_osc_clk;
    logic [31:0] hrdata;
    logic ext_count_input, gate_pin, second_comparator_output;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] q;
    gtc_timer dut_u (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ext_count_input(ext_count_input), .gate_pin(gate_pin),
        .second_comparator_output(second_comparator_output), .lp_osc_clk(lp_osc_clk),
        .lp_osc_en(lp_osc_en), .irq(irq));
    gtc_far_end far_u (.core_clk(core_clk), .lp_osc_en(lp_osc_en),
        .ext_count_input(ext_count_input), .gate_pin(gate_pin),
        .second_comparator_output(second_comparator_output), .lp_osc_clk(lp_osc_clk));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic conclude();
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, {31'h0, HRESP_OKAY});
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        compares++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h want=%h..%h", $time, got, lo, hi);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e, e);
    endtask : rdchk
    // Clear count and prescaler, count for a fixed span, stop, check and recheck the hold
    task automatic run(input logic [7:0] ctl, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] c;
        wr(OFF_COUNT_LOW_BYTE, 32'h0);
        wr(OFF_COUNT_HIGH_BYTE, 32'h0);
        wr(OFF_TIMER_CONTROL, {24'h0, ctl});
        far_u.pulses(32);
        repeat (8) @(posedge core_clk);
        wr(OFF_TIMER_CONTROL, 32'h0);
        bus(1'b0, OFF_COUNT_LOW_BYTE, 32'h0);
        c = q;
        chk(c, lo, hi);
        repeat (20) @(posedge core_clk);
        rdchk(OFF_COUNT_LOW_BYTE, c);
    endtask : run
    initial begin
        #(25 * 30000);
        num_errors++;
        conclude();
    end
    initial begin
        logic lv;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        rdchk(OFF_TIMER_CONTROL, 32'h0);
        rdchk(OFF_COMPARATOR_AUX_CONTROL, 32'h2);
        rdchk(8'hFC, 32'h0);
        wr(OFF_TIMER_CONTROL, 32'hFF);
        rdchk(OFF_TIMER_CONTROL, 32'hFF);
        chk({31'h0, lp_osc_en}, 32'h1, 32'h1);
        wr(OFF_TIMER_CONTROL, 32'h0);
        chk({31'h0, lp_osc_en}, 32'h0, 32'h0);
        wr(OFF_COUNT_LOW_BYTE, 32'hA5);
        wr(OFF_COUNT_HIGH_BYTE, 32'h5A);
        rdchk(OFF_COUNT_LOW_BYTE, 32'hA5);
        rdchk(OFF_COUNT_HIGH_BYTE, 32'h5A);
        for (int p = 0; p < 4; p++) begin
            run(8'(p << 4) | 8'h01, 32'h42 >> p, (32'h42 >> p) + 32'h1);
        end
        run(8'h05, 32'h42, 32'h43);
        run(8'h40, 32'h0, 32'h0);
        for (int b = 0; b < 2; b++) begin
            run(8'(b << 2) | 8'h03, 32'h20, 32'h20);
        end
        run(8'h0F, 32'hF, 32'h11);
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 2; p++) begin
                wr(OFF_COMPARATOR_AUX_CONTROL, 32'(s << 1));
                for (int a = 0; a < 2; a++) begin
                    lv = (a != 0) ? p[0] : !p[0];
                    far_u.set_gate((s != 0) ? lv : !lv, (s != 0) ? !lv : lv);
                    repeat (8) @(posedge core_clk);
                    run(8'(p << 7) | 8'h41, 32'(a) * 32'h42, 32'(a) * 32'h43);
                end
            end
        end
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_COUNT_LOW_BYTE, 32'hFF);
        wr(OFF_COUNT_HIGH_BYTE, 32'hFF);
        wr(OFF_TIMER_CONTROL, 32'h1);
        repeat (16) @(posedge core_clk);
        wr(OFF_TIMER_CONTROL, 32'h0);
        rdchk(OFF_COUNT_HIGH_BYTE, 32'h0);
        // Four or five ticks from FFFF: the first lands on zero
        bus(1'b0, OFF_COUNT_LOW_BYTE, 32'h0);
        chk(q, 32'h3, 32'h4);
        rdchk(OFF_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0, 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1, 32'h1);
        wr(OFF_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0, 32'h0);
        rdchk(OFF_IRQ_STATUS, 32'h0);
        conclude();
    end
endmodule : gtc_timer_test
`default_nettype wire
